// File: core/timer_cfg.svh
// constants for the timer channel capture/compare and status block
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define OFF_IOC 8'h00
`define OFF_TSR 8'h04
`define OFF_IER 8'h08
`define OFF_GRA 8'h0C
`define OFF_GRB 8'h10
`define OFF_CNT 8'h14
`define OFF_CTL 8'h18
`define IOC_RST 8'h08
`define TSR_RST 8'h78
`define IER_RST 8'h78
`define RSV_ONES 4'hF
`define FN_B_HI 6
`define FN_B_LO 4
`define FN_A_HI 2
`define FN_A_LO 0
`define FIX_BIT 3
`define FLAG_OVF 2
`define FLAG_B 1
`define FLAG_A 0
`define CTL_RUN 0
`define CTL_DOWN 1
`define CTL_UPDOWN 2
`define CNT_MAX 16'hFFFF
`define CNT_MIN 16'h0000
`define CNT_ONE 16'h0001
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`define CH_NO_TOGGLE 2
`define CH_DMA_LAST 3
`define CH_UPDOWN_FIRST 2
`endif

// File: core/timer_pkg.sv
// types for the timer channel capture/compare and status block
package timer_pkg;
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_OUT0 = 3'h1,
    FN_OUT1 = 3'h2,
    FN_TOGGLE = 3'h3,
    FN_CAP_RISE = 3'h4,
    FN_CAP_FALL = 3'h5,
    FN_CAP_BOTH = 3'h6,
    FN_CAP_BOTH2 = 3'h7
  } fn_t;
  typedef struct packed {
    logic ovf;
    logic b;
    logic a;
  } flags_t;
  typedef struct packed {
    logic updown;
    logic down;
    logic run;
  } ctl_t;
endpackage : timer_pkg

// File: core/timer_channel_io_and_status.sv
// one timer channel: compare/capture function select, status flags, axi4-lite registers
// Operation
// - register B function 000-011: compare, no pin action, drive 0, drive 1, toggle
// - register B function 100 rising, 101 falling, 11x both edges capture counter
// - register A function field bits 2-0 uses the same eight codes
// - channel 2 has no toggle; toggle code drives 1 on each match
// - compare output pins stay 0 after reset until first match
// - io_control bit 3 reads 1, bit 7 undefined; software writes bit 3 as 1
// - each set flag with its enable set requests a cpu interrupt
// - status_flags initialised to H'78/H'F8 on reset or standby
// - status_flags bits 6-3 read 1, bit 7 undefined; software writes ones
// - overflow flag set on wrap FFFF to 0000 or 0000 to FFFF
// - underflow only in up/down counting, channels 2 to 4
// - flag cleared by reading it as 1 then writing 0; 1 sets nothing
// - flag B set on register B compare match or capture load
// - flag A set on register A compare match or capture load
// - channels 0-3 clear flag A when its interrupt starts a dma transfer
// - enable bits 2,1,0 gate overflow, flag B, flag A requests
// - io_control initialised to H'08/H'88 on reset or standby
`timescale 1ns/10ps
`include "timer_cfg.svh"
module timer_channel_io_and_status
  import timer_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic standby,
  input wire logic count_tick,
  input wire logic dma_ack_a,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output logic pin_a_q,
  output logic pin_b_q,
  output logic pin_a_oe_n_q,
  output logic pin_b_oe_n_q,
  output logic irq_q,
  output logic dma_req_a_q,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready_q,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready_q,
  output logic [1:0] s_bresp_q,
  output logic s_bvalid_q,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready_q,
  output logic [31:0] s_rdata_q,
  output logic [1:0] s_rresp_q,
  output logic s_rvalid_q,
  input wire logic s_rready
);
  // ==========================================================
  // helpers
  function automatic logic is_cap(input fn_t fn);
    is_cap = fn[2];
  endfunction : is_cap

  function automatic logic drives_pin(input fn_t fn);
    drives_pin = !fn[2] && (fn != FN_NONE);
  endfunction : drives_pin

  function automatic logic cap_hit(input fn_t fn, input logic rise, input logic fall);
    case (fn)
      FN_CAP_RISE: cap_hit = rise;
      FN_CAP_FALL: cap_hit = fall;
      FN_CAP_BOTH, FN_CAP_BOTH2: cap_hit = rise || fall;
      default: cap_hit = 1'b0;
    endcase
  endfunction : cap_hit

  function automatic logic next_pin(input fn_t fn, input logic cur, input logic match);
    next_pin = cur;
    if (match) begin
      case (fn)
        FN_OUT0: next_pin = 1'b0;
        FN_OUT1: next_pin = 1'b1;
        FN_TOGGLE: next_pin = (CHANNEL == `CH_NO_TOGGLE) ? 1'b1 : !cur;
        default: next_pin = cur;
      endcase
    end
  endfunction : next_pin

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================
  // bus write channel
  logic aw_hold_q, w_hold_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, wr_ioc, wr_tsr, wr_ier, wr_gra, wr_grb, wr_cnt, wr_ctl, wr_bad;

  assign wr_fire = aw_hold_q && w_hold_q && !s_bvalid_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_awready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      waddr_q <= '0;
    end else begin
      s_awready_q <= s_awvalid && !s_awready_q && !aw_hold_q;
      if (s_awvalid && s_awready_q) begin
        aw_hold_q <= 1'b1;
        waddr_q <= s_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_wready_q <= 1'b0;
      w_hold_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      s_wready_q <= s_wvalid && !s_wready_q && !w_hold_q;
      if (s_wvalid && s_wready_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ioc = 1'b0;
    wr_tsr = 1'b0;
    wr_ier = 1'b0;
    wr_gra = 1'b0;
    wr_grb = 1'b0;
    wr_cnt = 1'b0;
    wr_ctl = 1'b0;
    wr_bad = 1'b0;
    if (waddr_q == `OFF_IOC) begin
      wr_ioc = wr_fire && wstrb_q[0];
    end else if (waddr_q == `OFF_TSR) begin
      wr_tsr = wr_fire && wstrb_q[0];
    end else if (waddr_q == `OFF_IER) begin
      wr_ier = wr_fire && wstrb_q[0];
    end else if (waddr_q == `OFF_GRA) begin
      wr_gra = wr_fire;
    end else if (waddr_q == `OFF_GRB) begin
      wr_grb = wr_fire;
    end else if (waddr_q == `OFF_CNT) begin
      wr_cnt = wr_fire;
    end else if (waddr_q == `OFF_CTL) begin
      wr_ctl = wr_fire && wstrb_q[0];
    end else begin
      wr_bad = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_bvalid_q <= 1'b0;
      s_bresp_q <= `RESP_OK;
    end else if (wr_fire) begin
      s_bvalid_q <= 1'b1;
      s_bresp_q <= wr_bad ? `RESP_ERR : `RESP_OK;
    end else if (s_bready) begin
      s_bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  fn_t fn_a_q, fn_b_q;
  flags_t ier_q, flag_q, flag_d, armed_q, set_ev, clr_ev;
  ctl_t ctl_q;
  logic [15:0] gra_q, grb_q, cnt_q, cnt_next;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fn_a_q <= fn_t'(3'(`IOC_RST >> `FN_A_LO));
      fn_b_q <= fn_t'(3'(`IOC_RST >> `FN_B_LO));
    end else if (standby) begin
      fn_a_q <= fn_t'(3'(`IOC_RST >> `FN_A_LO));
      fn_b_q <= fn_t'(3'(`IOC_RST >> `FN_B_LO));
    end else if (wr_ioc) begin
      fn_b_q <= fn_t'(wdata_q[`FN_B_HI:`FN_B_LO]);
      fn_a_q <= fn_t'(wdata_q[`FN_A_HI:`FN_A_LO]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ier_q <= flags_t'(3'(`IER_RST));
    end else if (standby) begin
      ier_q <= flags_t'(3'(`IER_RST));
    end else if (wr_ier) begin
      ier_q <= flags_t'(wdata_q[`FLAG_OVF:`FLAG_A]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_q <= '0;
    end else if (wr_ctl) begin
      ctl_q <= ctl_t'(wdata_q[`CTL_UPDOWN:`CTL_RUN]);
    end
  end

  // ==========================================================
  // counter
  logic step, dn, ovf_ev;
  // down counting only where up/down counting exists
  assign dn = ctl_q.down && ctl_q.updown && (CHANNEL >= `CH_UPDOWN_FIRST);
  assign step = count_tick && ctl_q.run;
  assign cnt_next = dn ? cnt_q - `CNT_ONE : cnt_q + `CNT_ONE;
  assign ovf_ev = step && (dn ? (cnt_q == `CNT_MIN) : (cnt_q == `CNT_MAX));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (wr_cnt) begin
      cnt_q <= merge16(cnt_q, wdata_q, wstrb_q);
    end else if (step) begin
      cnt_q <= cnt_next;
    end
  end

  // ==========================================================
  // capture inputs and compare matches
  logic [2:0] sync_a_q, sync_b_q;
  logic lvl_a_q, lvl_b_q;
  logic rise_a, fall_a, rise_b, fall_b, cap_a, cap_b, match_a, match_b;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
    end else begin
      sync_a_q <= {sync_a_q[1:0], pin_a_in};
      sync_b_q <= {sync_b_q[1:0], pin_b_in};
      // accepted level moves only when stages 2 and 3 agree
      if (sync_a_q[2] == sync_a_q[1]) begin
        lvl_a_q <= sync_a_q[2];
      end
      if (sync_b_q[2] == sync_b_q[1]) begin
        lvl_b_q <= sync_b_q[2];
      end
    end
  end

  // edges from agreeing second and third stages
  assign rise_a = sync_a_q[1] && sync_a_q[2] && !lvl_a_q;
  assign fall_a = !sync_a_q[1] && !sync_a_q[2] && lvl_a_q;
  assign rise_b = sync_b_q[1] && sync_b_q[2] && !lvl_b_q;
  assign fall_b = !sync_b_q[1] && !sync_b_q[2] && lvl_b_q;
  assign cap_b = cap_hit(fn_b_q, rise_b, fall_b);
  assign cap_a = cap_hit(fn_a_q, rise_a, fall_a);
  // match when the counter steps onto the register
  assign match_a = step && !is_cap(fn_a_q) && (cnt_next == gra_q);
  assign match_b = step && !is_cap(fn_b_q) && (cnt_next == grb_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gra_q <= '0;
      grb_q <= '0;
    end else begin
      if (cap_a) begin
        gra_q <= cnt_q;
      end else if (wr_gra) begin
        gra_q <= merge16(gra_q, wdata_q, wstrb_q);
      end
      if (cap_b) begin
        grb_q <= cnt_q;
      end else if (wr_grb) begin
        grb_q <= merge16(grb_q, wdata_q, wstrb_q);
      end
    end
  end

  // pins low from reset until first match
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_a_oe_n_q <= 1'b1;
      pin_b_oe_n_q <= 1'b1;
    end else if (standby) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_a_oe_n_q <= 1'b1;
      pin_b_oe_n_q <= 1'b1;
    end else begin
      // toggle replaced by drive 1 on channel 2
      pin_a_q <= next_pin(fn_a_q, pin_a_q, match_a);
      pin_b_q <= next_pin(fn_b_q, pin_b_q, match_b);
      pin_a_oe_n_q <= !drives_pin(fn_a_q);
      pin_b_oe_n_q <= !drives_pin(fn_b_q);
    end
  end

  // ==========================================================
  // bus read channel
  logic [31:0] rd_data;
  logic rd_bad, rd_fire;
  assign rd_fire = s_arvalid && s_arready_q;

  always_comb begin
    rd_data = '0;
    rd_bad = 1'b0;
    if (s_araddr == `OFF_IOC) begin
      // bit 3 reads one, bit 7 reads zero
      rd_data[7:0] = {1'b0, fn_b_q, 1'b1, fn_a_q};
    end else if (s_araddr == `OFF_TSR) begin
      rd_data[7:0] = {1'b0, `RSV_ONES, flag_q};
    end else if (s_araddr == `OFF_IER) begin
      rd_data[7:0] = {1'b0, `RSV_ONES, ier_q};
    end else if (s_araddr == `OFF_GRA) begin
      rd_data[15:0] = gra_q;
    end else if (s_araddr == `OFF_GRB) begin
      rd_data[15:0] = grb_q;
    end else if (s_araddr == `OFF_CNT) begin
      rd_data[15:0] = cnt_q;
    end else if (s_araddr == `OFF_CTL) begin
      rd_data[2:0] = ctl_q;
    end else begin
      rd_bad = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_arready_q <= 1'b0;
      s_rvalid_q <= 1'b0;
      s_rdata_q <= '0;
      s_rresp_q <= `RESP_OK;
    end else begin
      s_arready_q <= s_arvalid && !s_arready_q && !s_rvalid_q;
      if (rd_fire) begin
        s_rvalid_q <= 1'b1;
        s_rdata_q <= rd_data;
        s_rresp_q <= rd_bad ? `RESP_ERR : `RESP_OK;
      end else if (s_rready) begin
        s_rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status flags and interrupt
  // flag B on match or capture
  // flag A on match or capture
  assign set_ev = '{ovf: ovf_ev, b: match_b || cap_b, a: match_a || cap_a};
  always_comb begin
    // clear needs earlier read as one and a written zero
    clr_ev = wr_tsr ? (armed_q & ~flags_t'(wdata_q[`FLAG_OVF:`FLAG_A])) : '0;
    // dma activation clears flag A on channels 0-3
    if (dma_ack_a && (CHANNEL <= `CH_DMA_LAST)) begin
      clr_ev.a = 1'b1;
    end
    flag_d = set_ev | (flag_q & ~clr_ev);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= flags_t'(3'(`TSR_RST));
      armed_q <= '0;
    end else if (standby) begin
      flag_q <= flags_t'(3'(`TSR_RST));
      armed_q <= '0;
    end else begin
      flag_q <= flag_d;
      if (rd_fire && (s_araddr == `OFF_TSR)) begin
        armed_q <= flag_q;
      end else begin
        armed_q <= armed_q & ~clr_ev;
      end
    end
  end

  // interrupt while an enabled flag is set
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
      dma_req_a_q <= 1'b0;
    end else begin
      irq_q <= |(flag_d & ier_q) && !standby;
      dma_req_a_q <= flag_d.a && ier_q.a && !standby;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_toggle_pin_b: assert property (
    match_b && fn_b_q == FN_TOGGLE && CHANNEL != `CH_NO_TOGGLE && !standby |=> pin_b_q != $past(pin_b_q))
    else $error("pin b did not toggle on match");
  a_capture_load_b: assert property (
    cap_b && !standby |=> grb_q == $past(cnt_q) && flag_q.b)
    else $error("register b capture failed");
  a_drive_zero_a: assert property (
    match_a && fn_a_q == FN_OUT0 && !standby |=> !pin_a_q)
    else $error("pin a not driven low on match");
  a_ch2_toggle_one: assert property (
    match_a && fn_a_q == FN_TOGGLE && CHANNEL == `CH_NO_TOGGLE && !standby |=> pin_a_q)
    else $error("channel 2 toggle code did not drive one");
  a_ioc_fixed_bit: assert property (
    rd_fire && s_araddr == `OFF_IOC |=> s_rdata_q[`FIX_BIT] && s_rvalid_q)
    else $error("io_control bit 3 not read as one");
  a_irq_follows: assert property (
    $stable(ier_q) && !$past(standby) |-> irq_q == |(flag_q & ier_q))
    else $error("enabled flag without interrupt");
  a_ovf_wrap: assert property (
    step && !dn && !wr_cnt && cnt_q == `CNT_MAX && !standby |=> flag_q.ovf && cnt_q == `CNT_MIN)
    else $error("overflow not flagged on wrap");
  a_set_beats_clear: assert property (
    set_ev.a && clr_ev.a && !standby |=> flag_q.a)
    else $error("flag a lost under clear");
  a_no_set_by_one: assert property (
    wr_tsr && !flag_q.b && !set_ev.b |=> !flag_q.b)
    else $error("written one set flag b");
  a_dma_clear: assert property (
    dma_ack_a && !set_ev.a && CHANNEL <= `CH_DMA_LAST |=> !flag_q.a)
    else $error("dma activation left flag a set");

  c_match_a: cover property (match_a ##1 irq_q);
  c_capture_b: cover property (cap_b ##1 flag_q.b);
  c_set_clear: cover property (set_ev.a && clr_ev.a);
  c_sw_clear: cover property (rd_fire && s_araddr == `OFF_TSR ##[1:20] wr_tsr && |clr_ev);
endmodule : timer_channel_io_and_status

// File: tb/pin_model.sv
// capture pin source standing at the far side of the timer channel
`timescale 1ns/10ps
module pin_model (
  input wire logic clk_sys,
  output logic pin_a,
  output logic pin_b
);
  // ==========================================
  // pin levels, changed just after a clock edge
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // hold gives the slow or prompt source
  task drive(input logic a, input logic b, input int hold);
    begin
      @(posedge clk_sys);
      pin_a <= a;
      pin_b <= b;
      repeat (hold) @(posedge clk_sys);
    end
  endtask : drive
endmodule : pin_model

// File: tb/tb.sv
// self-checking bench for timer channel 0 and a channel 2 twin over a shared axi4-lite port
`timescale 1ns/10ps
`include "timer_cfg.svh"
module tb import timer_pkg::*;;
  // ==========================================
  // signals
  logic clk_sys = 1'b0, rst = 1'b1, standby = 1'b0, count_tick = 1'b0, dma_ack_a = 1'b0;
  logic pin_a_in, pin_b_in, pin_a_q, pin_b_q, pin_a_oe_n_q, pin_b_oe_n_q, irq_q, dma_req_a_q;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata_q, last_data;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready_q, s_wready_q, s_bvalid_q, s_arready_q, s_rvalid_q, exp_pin;
  logic [1:0] s_bresp_q, s_rresp_q, last_resp;
  logic pin_a2, pin_b2, exp_pin2;
  logic [31:0] rdata2, last_data2;
  int err_count = 0, check_count = 0, cycles = 0;
  fn_t seq [6] = '{FN_OUT1, FN_OUT0, FN_TOGGLE, FN_TOGGLE, FN_OUT1, FN_NONE};
  always #2.5 clk_sys = ~clk_sys;
  pin_model pm (.clk_sys, .pin_a(pin_a_in), .pin_b(pin_b_in));
  timer_channel_io_and_status #(.CHANNEL(0)) uut (
    .clk_sys, .rst, .standby, .count_tick, .dma_ack_a, .pin_a_in, .pin_b_in,
    .pin_a_q, .pin_b_q, .pin_a_oe_n_q, .pin_b_oe_n_q, .irq_q, .dma_req_a_q,
    .s_awaddr, .s_awvalid, .s_awready_q, .s_wdata, .s_wstrb, .s_wvalid, .s_wready_q,
    .s_bresp_q, .s_bvalid_q, .s_bready, .s_araddr, .s_arvalid, .s_arready_q,
    .s_rdata_q, .s_rresp_q, .s_rvalid_q, .s_rready
  );
  // channel 2 twin on the same bus: no toggle, down counting allowed
  timer_channel_io_and_status #(.CHANNEL(2)) uut2 (
    .clk_sys, .rst, .standby, .count_tick, .dma_ack_a, .pin_a_in, .pin_b_in,
    .pin_a_q(pin_a2), .pin_b_q(pin_b2), .pin_a_oe_n_q(), .pin_b_oe_n_q(), .irq_q(), .dma_req_a_q(),
    .s_awaddr, .s_awvalid, .s_awready_q(), .s_wdata, .s_wstrb, .s_wvalid, .s_wready_q(),
    .s_bresp_q(), .s_bvalid_q(), .s_bready, .s_araddr, .s_arvalid, .s_arready_q(),
    .s_rdata_q(rdata2), .s_rresp_q(), .s_rvalid_q(), .s_rready
  );
  // ==========================================
  // checking and closing
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task end_of_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  // ==========================================
  // bus and event tasks
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic k, m, b;
    begin
      b = 1'b0;
      @(posedge clk_sys);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!b) begin
        @(negedge clk_sys);
        k = s_awvalid & (s_awready_q === 1'b1);
        m = s_wvalid & (s_wready_q === 1'b1);
        b = s_bvalid_q === 1'b1;
        if (b) last_resp = s_bresp_q;
        @(posedge clk_sys);
        if (k) s_awvalid <= 1'b0;
        if (m) s_wvalid <= 1'b0;
        if (b) s_bready <= 1'b0;
      end
      repeat (2) @(negedge clk_sys);
    end
  endtask : wr
  task rd(input logic [7:0] a);
    logic k, v;
    begin
      v = 1'b0;
      @(posedge clk_sys);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      while (!v) begin
        @(negedge clk_sys);
        k = s_arvalid & (s_arready_q === 1'b1);
        v = s_rvalid_q === 1'b1;
        if (v) last_data = s_rdata_q;
        if (v) last_data2 = rdata2;
        if (v) last_resp = s_rresp_q;
        @(posedge clk_sys);
        if (k) s_arvalid <= 1'b0;
        if (v) s_rready <= 1'b0;
      end
      @(negedge clk_sys);
    end
  endtask : rd
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(last_data, e);
  endtask : rc
  task pulse_tick;
    @(posedge clk_sys);
    count_tick <= 1'b1;
    @(posedge clk_sys);
    count_tick <= 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse_tick
  task pins(input logic a, input logic b);
    pm.drive(a, b, 8);
    @(negedge clk_sys);
  endtask : pins
  // ==========================================
  // scenarios
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    rc(`OFF_IOC, 32'h08); // reset value
    rc(`OFF_TSR, 32'h78); // reset value
    rc(`OFF_IER, 32'h78); // enables off
    check(32'({pin_b_q, pin_a_q, pin_b_oe_n_q, pin_a_oe_n_q, irq_q}), 32'h06); // pins low
    wr(`OFF_IOC, 32'hFF);
    rc(`OFF_IOC, 32'h7F); // fixed bits
    wr(`OFF_GRA, 32'h10);
    wr(`OFF_GRB, 32'h10);
    wr(`OFF_CTL, 32'h1);
    exp_pin = 1'b0;
    exp_pin2 = 1'b0;
    foreach (seq[i]) begin
      wr(`OFF_IOC, {24'h0, 1'b0, seq[i], 1'b1, seq[i]});
      wr(`OFF_CNT, 32'h0F);
      pulse_tick;
      if (seq[i] == FN_OUT0) exp_pin = 1'b0;
      if (seq[i] == FN_OUT1) exp_pin = 1'b1;
      if (seq[i] == FN_TOGGLE) exp_pin = ~exp_pin;
      exp_pin2 = (seq[i] == FN_OUT0) ? 1'b0 : (seq[i] == FN_NONE) ? exp_pin2 : 1'b1;
      check(32'({pin_b_q, pin_a_q}), 32'({exp_pin, exp_pin})); // pin action
      check(32'({pin_b2, pin_a2}), 32'({exp_pin2, exp_pin2})); // channel 2 toggle gives 1
      check(32'({pin_b_oe_n_q, pin_a_oe_n_q}), (seq[i] == FN_NONE) ? 32'h3 : 32'h0); // drive enable
      rc(`OFF_TSR, 32'h7B); // match flags
      wr(`OFF_TSR, 32'h78); // ones kept in bits 6-3
    end
    rc(`OFF_TSR, 32'h78); // read then clear
    @(posedge clk_sys);
    standby <= 1'b1;
    repeat (3) @(posedge clk_sys);
    standby <= 1'b0;
    @(negedge clk_sys);
    check(32'({pin_b_q, pin_a_q}), 32'h0); // standby pins
    rc(`OFF_IOC, 32'h08); // standby value
    wr(`OFF_CTL, 32'h1);
    wr(`OFF_IER, 32'h7F);
    wr(`OFF_CNT, 32'hFFFF);
    pulse_tick;
    rc(`OFF_TSR, 32'h7C); // wrap sets overflow
    check(32'(irq_q), 32'h1); // enabled flag
    wr(`OFF_IER, 32'h78);
    check(32'(irq_q), 32'h0); // masked flag
    wr(`OFF_TSR, 32'h78);
    wr(`OFF_CTL, 32'h7);
    wr(`OFF_CNT, 32'h0);
    pulse_tick;
    rc(`OFF_TSR, 32'h78); // no underflow here
    check(last_data2, 32'h7C); // channel 2 underflow
    wr(`OFF_TSR, 32'hFF);
    rc(`OFF_TSR, 32'h78); // ones set nothing
    wr(`OFF_CTL, 32'h1);
    wr(`OFF_CNT, 32'h0F);
    pulse_tick;
    wr(`OFF_TSR, 32'h78);
    rc(`OFF_TSR, 32'h7B); // clear needs read
    wr(`OFF_TSR, 32'h78);
    wr(`OFF_IER, 32'h79);
    wr(`OFF_CNT, 32'h0F);
    pulse_tick;
    check(32'({dma_req_a_q, irq_q}), 32'h3); // flag a request
    @(posedge clk_sys);
    dma_ack_a <= 1'b1;
    @(posedge clk_sys);
    dma_ack_a <= 1'b0;
    repeat (2) @(negedge clk_sys);
    rc(`OFF_TSR, 32'h7A); // dma clears flag a
    wr(`OFF_TSR, 32'h78);
    wr(`OFF_CNT, 32'h0F);
    @(posedge clk_sys);
    count_tick <= 1'b1;
    dma_ack_a <= 1'b1;
    @(posedge clk_sys);
    count_tick <= 1'b0;
    dma_ack_a <= 1'b0;
    repeat (2) @(negedge clk_sys);
    rc(`OFF_TSR, 32'h7B); // match beats dma clear
    wr(`OFF_TSR, 32'h78);
    wr(`OFF_CTL, 32'h0);
    wr(`OFF_CNT, 32'h1234);
    wr(`OFF_IOC, {24'h0, 1'b0, FN_CAP_FALL, 1'b1, FN_CAP_RISE});
    pins(1'b1, 1'b1);
    rc(`OFF_GRA, 32'h1234); // rising capture
    rc(`OFF_TSR, 32'h79); // capture flag
    wr(`OFF_TSR, 32'h78);
    wr(`OFF_CNT, 32'h4321);
    pins(1'b1, 1'b0);
    rc(`OFF_GRB, 32'h4321); // falling capture
    rc(`OFF_GRA, 32'h1234); // no edge no load
    rc(`OFF_TSR, 32'h7A); // capture flag
    wr(`OFF_IOC, {24'h0, 1'b0, FN_NONE, 1'b1, FN_CAP_BOTH2});
    wr(`OFF_CNT, 32'h0055);
    pins(1'b0, 1'b0);
    rc(`OFF_GRA, 32'h0055); // both edges
    rd(8'h1C);
    check(32'(last_resp), 32'(`RESP_ERR));
    check(last_data, 32'h0);
    wr(8'h1C, 32'h1);
    check(32'(last_resp), 32'(`RESP_ERR));
    end_of_test;
  end
endmodule : tb
